// ### shared/aisc_pkg.sv
// Constants, register layout and carrier types of the acquisition interrupt and scan block
package aisc_pkg;
    // Bus geometry
    localparam int AISC_AW = 8;
    localparam int AISC_DW = 32;
    // Register byte offsets
    localparam logic [7:0] AISC_OFF_CTRL = 8'h00;
    localparam logic [7:0] AISC_OFF_SWTRIG = 8'h04;
    localparam logic [7:0] AISC_OFF_DATA = 8'h08;
    localparam logic [7:0] AISC_OFF_STAT = 8'h0c;
    localparam logic [7:0] AISC_OFF_PEND_CLR = 8'h10;
    localparam logic [7:0] AISC_OFF_PACER_A = 8'h14;
    localparam logic [7:0] AISC_OFF_PACER_B = 8'h18;
    localparam logic [7:0] AISC_OFF_PRETRIG = 8'h1c;
    localparam logic [7:0] AISC_OFF_IRQ_EN = 8'h20;
    localparam logic [7:0] AISC_OFF_IRQ_STAT = 8'h24;
    localparam logic [7:0] AISC_OFF_IRQ_CLR = 8'h28;
    // Control register fields
    localparam int AISC_CTRL_SRC1_LSB = 0;
    localparam int AISC_CTRL_SRC2_LSB = 2;
    localparam int AISC_CTRL_SCAN_BIT = 4;
    localparam int AISC_CTRL_PACER_BIT = 5;
    localparam int AISC_CTRL_CH_LSB = 8;
    localparam logic [15:0] AISC_CTRL_MASK = 16'h0f3f;
    localparam logic [15:0] AISC_CTRL_RST = 16'h0000;
    // Status register fields
    localparam int AISC_ST_PEND1 = 0;
    localparam int AISC_ST_PEND2 = 1;
    localparam int AISC_ST_DREADY = 2;
    localparam int AISC_ST_HALF = 3;
    localparam int AISC_ST_FULL = 4;
    localparam int AISC_ST_BUSY = 5;
    localparam int AISC_ST_CH_LSB = 8;
    localparam int AISC_ST_PTOUT = 12;
    // Pre-trigger register fields
    localparam int AISC_PT_MODE_LSB = 16;
    // Interrupt source codes, first line
    localparam logic [1:0] AISC_SEL1_OFF = 2'h0;
    localparam logic [1:0] AISC_SEL1_EOC = 2'h1;
    localparam logic [1:0] AISC_SEL1_HALF = 2'h2;
    // Interrupt source codes, second line
    localparam logic [1:0] AISC_SEL2_OFF = 2'h0;
    localparam logic [1:0] AISC_SEL2_PACER = 2'h1;
    localparam logic [1:0] AISC_SEL2_EXT = 2'h2;
    // Event bits of the interrupt status register
    localparam int AISC_EV_EOC = 0;
    localparam int AISC_EV_HALF = 1;
    localparam int AISC_EV_PACER = 2;
    localparam int AISC_EV_EXT = 3;
    localparam int AISC_EV_OVR = 4;
    localparam int AISC_NEV = 5;
    // Counter modes and widths
    localparam logic [2:0] AISC_CM_TERM = 3'h0;
    localparam logic [2:0] AISC_CM_ONESHOT = 3'h1;
    localparam logic [2:0] AISC_CM_RATE = 3'h2;
    localparam int AISC_CNT_W = 16;
    localparam logic [15:0] AISC_CNT_ONE = 16'h0001;
    localparam logic [15:0] AISC_DIV_RST = 16'h0000;
    // Converter widths
    localparam int AISC_CH_W = 4;
    localparam int AISC_STD_BITS = 12;
    localparam int AISC_HR_BITS = 16;
    // Conversion sequencer states
    typedef enum logic [2:0] {
        AISC_CV_IDLE = 3'b001,
        AISC_CV_START = 3'b010,
        AISC_CV_WAIT = 3'b100
    } aisc_cv_t;
    // Load request for the pre-trigger counter
    typedef struct packed {
        logic load;
        logic [2:0] mode;
        logic [AISC_CNT_W-1:0] value;
    } aisc_cnt_cfg_t;
    // Byte-lane merge of a bus write into a register image
    function automatic logic [31:0] aisc_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            aisc_merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : aisc_merge
endpackage : aisc_pkg

// ### rtl/aisc_pretrig_cnt.sv
// Pre-trigger down counter with terminal, one-shot and rate modes
module aisc_pretrig_cnt
    import aisc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Load request and count enable
    input wire aisc_cnt_cfg_t cfg_i,
    input wire logic tick_i,
    // Count value and output
    output logic [AISC_CNT_W-1:0] count_o,
    output logic out_o
);
    typedef struct packed {
        logic [2:0] mode;
        logic [AISC_CNT_W-1:0] count;
        logic [AISC_CNT_W-1:0] reload;
        logic run;
        logic out;
    } aisc_cnt_state_t;

    aisc_cnt_state_t s_reg;
    aisc_cnt_state_t s_next;

    // Load wins over counting; a zero load parks the output high
    always_comb begin
        s_next = s_reg;
        if (cfg_i.load) begin
            s_next.mode = cfg_i.mode;
            s_next.count = cfg_i.value;
            s_next.reload = cfg_i.value;
            s_next.run = (cfg_i.value != '0);
            s_next.out = (cfg_i.value == '0);
        end else if (s_reg.run && tick_i) begin
            if (s_reg.count == AISC_CNT_ONE) begin
                s_next.out = 1'b1;
                if (s_reg.mode == AISC_CM_RATE) begin
                    s_next.count = s_reg.reload;
                end else begin
                    s_next.count = '0;
                    s_next.run = 1'b0;
                end
            end else begin
                s_next.count = s_reg.count - AISC_CNT_ONE;
                s_next.out = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count_o = s_reg.count;
    assign out_o = s_reg.out;

    property p_oneshot_zero;
        @(posedge clk_i) disable iff (rst_i)
        cfg_i.load && cfg_i.mode == AISC_CM_ONESHOT && cfg_i.value == '0
            ##1 !cfg_i.load[*2] |-> out_o && count_o == '0;
    endproperty
    a_oneshot_zero: assert property (p_oneshot_zero) else $error("zero one-shot not parked");

    property p_halted_still;
        @(posedge clk_i) disable iff (rst_i)
        out_o && !s_reg.run && !cfg_i.load |=> out_o && $stable(count_o);
    endproperty
    a_halted_still: assert property (p_halted_still) else $error("halted counter moved");
endmodule : aisc_pretrig_cnt

// ### rtl/aisc_top.sv
// Acquisition interrupt lines, pacer, conversion sequencer and scan control
// Behaviour
// - Two interrupt lines, each with own select
// - First select: 0 off, 1 EOC, 2 half-full
// - Second select: 0 off, 1 pacer, 2 external
// - Pending request holds and blocks until cleared
// - Per-line pending status reads 0 or 1
// - Pre-trigger count readable without disturbing it
// - One-shot zero count drives output high, halted
// - Half-full visible; full FIFO flags overrun
// - Software trigger converts once; 12-bit result
// - High-resolution variant yields 16-bit result
// - Autoscan steps 0 to last, then wraps
// - Without autoscan, only the configured channel
// - Either pacer divider zero stops pacing
module aisc_top
    import aisc_pkg::*;
#(
    parameter bit HIRES = 1'b0,
    parameter int CH_W = AISC_CH_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AISC_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [AISC_DW-1:0] wb_dat_i,
    output logic [AISC_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt outputs
    output logic irq_o,
    output logic first_irq_line_o,
    output logic second_irq_line_o,
    // Converter pins
    output logic conv_start_o,
    output logic [CH_W-1:0] adc_channel_o,
    input wire logic adc_done_i,
    input wire logic [AISC_HR_BITS-1:0] adc_data_i,
    // Sample FIFO flags, same clock
    input wire logic fifo_half_i,
    input wire logic fifo_full_i,
    // External interrupt pin and pre-trigger output
    input wire logic ext_irq_i,
    output logic pretrig_out_o
);
    typedef struct packed {
        logic ack;
        logic [AISC_DW-1:0] rdat;
        logic [15:0] ctrl;
        logic [CH_W-1:0] scan_ch;
        logic pend1;
        logic pend2;
        logic [AISC_NEV-1:0] irq_en;
        logic [AISC_NEV-1:0] irq_stat;
        logic irq;
        logic [15:0] div_a;
        logic [15:0] div_b;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic pacer_tick;
        aisc_cv_t cv;
        logic conv_start;
        logic [CH_W-1:0] adc_ch;
        logic [AISC_HR_BITS-1:0] result;
        logic dready;
        logic half_q;
        logic done_s1;
        logic done_s2;
        logic done_q;
        logic ext_s1;
        logic ext_s2;
        logic ext_q;
        logic [AISC_HR_BITS-1:0] dat_s1;
        logic [AISC_HR_BITS-1:0] dat_s2;
    } aisc_top_state_t;

    aisc_top_state_t s_reg;
    aisc_top_state_t s_next;

    logic req;
    logic wr_now;
    logic rd_now;
    logic wr_ctrl;
    logic wr_sw;
    logic wr_pend_clr;
    logic wr_irq_clr;
    logic wr_pt;
    logic rd_data;
    logic [1:0] src1;
    logic [1:0] src2;
    logic scan_en;
    logic pacer_en;
    logic [CH_W-1:0] last_ch;
    logic done_rise;
    logic ext_rise;
    logic ev_eoc;
    logic start_req;
    logic [AISC_NEV-1:0] ev;
    logic req1;
    logic req2;
    logic [AISC_CNT_W-1:0] pt_count;
    logic pt_out;
    aisc_cnt_cfg_t pt_cfg;
    logic [15:0] status;
    logic [AISC_HR_BITS-1:0] conv_word;

    // Bus strobes; writes and read side effects land on the ack edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_now = req & wb_we_i & s_reg.ack;
    assign rd_now = req & ~wb_we_i & s_reg.ack;
    assign wr_ctrl = wr_now && wb_adr_i == AISC_OFF_CTRL;
    assign wr_sw = wr_now && wb_adr_i == AISC_OFF_SWTRIG;
    assign wr_pend_clr = wr_now && wb_adr_i == AISC_OFF_PEND_CLR;
    assign wr_irq_clr = wr_now && wb_adr_i == AISC_OFF_IRQ_CLR;
    assign wr_pt = wr_now && wb_adr_i == AISC_OFF_PRETRIG;
    assign rd_data = rd_now && wb_adr_i == AISC_OFF_DATA;

    // Control fields
    assign src1 = s_reg.ctrl[AISC_CTRL_SRC1_LSB +: 2];
    assign src2 = s_reg.ctrl[AISC_CTRL_SRC2_LSB +: 2];
    assign scan_en = s_reg.ctrl[AISC_CTRL_SCAN_BIT];
    assign pacer_en = s_reg.ctrl[AISC_CTRL_PACER_BIT];
    assign last_ch = s_reg.ctrl[AISC_CTRL_CH_LSB +: CH_W];

    // Edges are taken after the synchronisers, never on the first stage
    assign done_rise = s_reg.done_s2 & ~s_reg.done_q;
    assign ext_rise = s_reg.ext_s2 & ~s_reg.ext_q;
    assign ev_eoc = done_rise && s_reg.cv == AISC_CV_WAIT;
    assign start_req = wr_sw | (pacer_en & s_reg.pacer_tick);

    // Standard variant keeps only the low result bits
    assign conv_word = HIRES ? s_reg.dat_s2
        : {{(AISC_HR_BITS-AISC_STD_BITS){1'b0}}, s_reg.dat_s2[AISC_STD_BITS-1:0]};

    // Event vector feeding both the lines and the sticky status
    always_comb begin
        ev = '0;
        ev[AISC_EV_EOC] = ev_eoc;
        ev[AISC_EV_HALF] = fifo_half_i & ~s_reg.half_q;
        ev[AISC_EV_PACER] = s_reg.pacer_tick;
        ev[AISC_EV_EXT] = ext_rise;
        ev[AISC_EV_OVR] = fifo_full_i;
    end

    // Per-line source decode, independent selects
    assign req1 = (src1 == AISC_SEL1_EOC && ev[AISC_EV_EOC])
        || (src1 == AISC_SEL1_HALF && ev[AISC_EV_HALF]);
    assign req2 = (src2 == AISC_SEL2_PACER && ev[AISC_EV_PACER])
        || (src2 == AISC_SEL2_EXT && ev[AISC_EV_EXT]);

    // Pre-trigger counter counts completed conversions
    assign pt_cfg.load = wr_pt;
    assign pt_cfg.mode = wb_dat_i[AISC_PT_MODE_LSB +: 3];
    assign pt_cfg.value = wb_dat_i[AISC_CNT_W-1:0];

    aisc_pretrig_cnt u_pretrig (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(pt_cfg),
        .tick_i(ev_eoc),
        .count_o(pt_count),
        .out_o(pt_out)
    );

    // Status word
    always_comb begin
        status = '0;
        status[AISC_ST_PEND1] = s_reg.pend1;
        status[AISC_ST_PEND2] = s_reg.pend2;
        status[AISC_ST_DREADY] = s_reg.dready;
        status[AISC_ST_HALF] = fifo_half_i;
        status[AISC_ST_FULL] = fifo_full_i;
        status[AISC_ST_BUSY] = s_reg.cv != AISC_CV_IDLE;
        status[AISC_ST_CH_LSB +: CH_W] = s_reg.scan_ch;
        status[AISC_ST_PTOUT] = pt_out;
    end

    // Next state of the whole block
    always_comb begin
        s_next = s_reg;
        s_next.conv_start = 1'b0;
        s_next.pacer_tick = 1'b0;
        // Synchronisers and edge history
        s_next.done_s1 = adc_done_i;
        s_next.done_s2 = s_reg.done_s1;
        s_next.done_q = s_reg.done_s2;
        s_next.ext_s1 = ext_irq_i;
        s_next.ext_s2 = s_reg.ext_s1;
        s_next.ext_q = s_reg.ext_s2;
        s_next.dat_s1 = adc_data_i;
        s_next.dat_s2 = s_reg.dat_s1;
        s_next.half_q = fifo_half_i;
        // One-cycle ack, answer data captured with it
        s_next.ack = req & ~s_reg.ack;
        if (req && !s_reg.ack) begin
            case (wb_adr_i)
                AISC_OFF_CTRL: s_next.rdat = {16'h0000, s_reg.ctrl};
                AISC_OFF_DATA: s_next.rdat = {16'h0000, s_reg.result};
                AISC_OFF_STAT: s_next.rdat = {16'h0000, status};
                AISC_OFF_PACER_A: s_next.rdat = {16'h0000, s_reg.div_a};
                AISC_OFF_PACER_B: s_next.rdat = {16'h0000, s_reg.div_b};
                AISC_OFF_PRETRIG: s_next.rdat = {16'h0000, pt_count};
                AISC_OFF_IRQ_EN: s_next.rdat = {27'h0000000, s_reg.irq_en};
                AISC_OFF_IRQ_STAT: s_next.rdat = {27'h0000000, s_reg.irq_stat};
                default: s_next.rdat = '0;
            endcase
        end
        // Register writes
        if (wr_ctrl) begin
            s_next.ctrl = AISC_CTRL_MASK & 16'(aisc_merge({16'h0000, s_reg.ctrl}, wb_dat_i,
                                                          wb_sel_i));
            s_next.scan_ch = '0;
        end
        if (wr_now && wb_adr_i == AISC_OFF_PACER_A) begin
            s_next.div_a = 16'(aisc_merge({16'h0000, s_reg.div_a}, wb_dat_i, wb_sel_i));
        end
        if (wr_now && wb_adr_i == AISC_OFF_PACER_B) begin
            s_next.div_b = 16'(aisc_merge({16'h0000, s_reg.div_b}, wb_dat_i, wb_sel_i));
        end
        if (wr_now && wb_adr_i == AISC_OFF_IRQ_EN) begin
            s_next.irq_en = AISC_NEV'(aisc_merge({27'h0000000, s_reg.irq_en}, wb_dat_i,
                                                 wb_sel_i));
        end
        // Pacer: two cascaded dividers, either at zero halts it
        if (!pacer_en || s_reg.div_a == '0 || s_reg.div_b == '0) begin
            s_next.cnt_a = '0;
            s_next.cnt_b = '0;
        end else if (s_reg.cnt_a == s_reg.div_a - AISC_CNT_ONE) begin
            s_next.cnt_a = '0;
            if (s_reg.cnt_b == s_reg.div_b - AISC_CNT_ONE) begin
                s_next.cnt_b = '0;
                s_next.pacer_tick = 1'b1;
            end else begin
                s_next.cnt_b = s_reg.cnt_b + AISC_CNT_ONE;
            end
        end else begin
            s_next.cnt_a = s_reg.cnt_a + AISC_CNT_ONE;
        end
        // Reading the result consumes it; a new result wins
        if (rd_data) begin
            s_next.dready = 1'b0;
        end
        // Conversion sequencer; triggers while busy are dropped
        case (s_reg.cv)
            AISC_CV_IDLE: begin
                if (start_req) begin
                    s_next.cv = AISC_CV_START;
                    s_next.conv_start = 1'b1;
                    s_next.adc_ch = scan_en ? s_reg.scan_ch : last_ch;
                    if (scan_en && !wr_ctrl) begin
                        s_next.scan_ch = (s_reg.scan_ch >= last_ch) ? '0
                            : s_reg.scan_ch + CH_W'(1);
                    end
                end
            end
            AISC_CV_START: begin
                s_next.cv = AISC_CV_WAIT;
            end
            AISC_CV_WAIT: begin
                if (done_rise) begin
                    s_next.cv = AISC_CV_IDLE;
                    s_next.result = conv_word;
                    s_next.dready = 1'b1;
                end
            end
            default: begin
                s_next.cv = AISC_CV_IDLE;
            end
        endcase
        // Pending lines: a raised request holds until the clear write
        if (req1) begin
            s_next.pend1 = 1'b1;
        end else if (wr_pend_clr) begin
            s_next.pend1 = 1'b0;
        end
        if (req2) begin
            s_next.pend2 = 1'b1;
        end else if (wr_pend_clr) begin
            s_next.pend2 = 1'b0;
        end
        // Sticky event status; set wins over a clear in the same cycle
        if (wr_irq_clr && wb_sel_i[0]) begin
            s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[AISC_NEV-1:0];
        end
        s_next.irq_stat = s_next.irq_stat | ev;
        s_next.irq = |(s_next.irq_stat & s_next.irq_en);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.ctrl <= AISC_CTRL_RST;
            s_reg.div_a <= AISC_DIV_RST;
            s_reg.div_b <= AISC_DIV_RST;
            s_reg.cv <= AISC_CV_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o = s_reg.rdat;
    assign wb_ack_o = s_reg.ack;
    assign irq_o = s_reg.irq;
    assign first_irq_line_o = s_reg.pend1;
    assign second_irq_line_o = s_reg.pend2;
    assign conv_start_o = s_reg.conv_start;
    assign adc_channel_o = s_reg.adc_ch;
    assign pretrig_out_o = pt_out;

    property p_line1_eoc;
        @(posedge clk_i) disable iff (rst_i)
        src1 == AISC_SEL1_EOC && ev_eoc |=> first_irq_line_o;
    endproperty
    a_line1_eoc: assert property (p_line1_eoc) else $error("EOC did not raise line one");

    property p_line1_off;
        @(posedge clk_i) disable iff (rst_i)
        src1 == AISC_SEL1_OFF && !first_irq_line_o |=> !first_irq_line_o;
    endproperty
    a_line1_off: assert property (p_line1_off) else $error("disabled line one raised");

    property p_line2_pacer;
        @(posedge clk_i) disable iff (rst_i)
        src2 == AISC_SEL2_PACER && s_reg.pacer_tick && src1 == AISC_SEL1_OFF && !first_irq_line_o
            |=> second_irq_line_o && !first_irq_line_o;
    endproperty
    a_line2_pacer: assert property (p_line2_pacer) else $error("pacer missed line two");

    property p_pend_hold;
        @(posedge clk_i) disable iff (rst_i)
        first_irq_line_o && !wr_pend_clr |=> first_irq_line_o;
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending dropped without clear");

    property p_clear_both;
        @(posedge clk_i) disable iff (rst_i)
        wr_pend_clr && !req1 && !req2 |=> !first_irq_line_o && !second_irq_line_o;
    endproperty
    a_clear_both: assert property (p_clear_both) else $error("clear left a line pending");

    property p_stat_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && !wb_ack_o && wb_adr_i == AISC_OFF_STAT
            |=> wb_ack_o && wb_dat_o[1:0] == $past({s_reg.pend2, s_reg.pend1});
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    property p_count_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && !wb_ack_o && wb_adr_i == AISC_OFF_PRETRIG
            |=> wb_dat_o[AISC_CNT_W-1:0] == $past(pt_count);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");

    property p_pacer_zero;
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.div_a == '0 || s_reg.div_b == '0) |=> !s_reg.pacer_tick;
    endproperty
    a_pacer_zero: assert property (p_pacer_zero) else $error("pacer ticked at zero");

    property p_scan_wrap;
        @(posedge clk_i) disable iff (rst_i)
        s_reg.cv == AISC_CV_IDLE && start_req && scan_en && !wr_ctrl
            && s_reg.scan_ch == last_ch |=> s_reg.scan_ch == '0 && conv_start_o;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

    property p_single_ch;
        @(posedge clk_i) disable iff (rst_i)
        conv_start_o && !scan_en && $past(!wr_ctrl) |-> adc_channel_o == last_ch;
    endproperty
    a_single_ch: assert property (p_single_ch) else $error("wrong fixed channel");

    property p_result;
        @(posedge clk_i) disable iff (rst_i)
        ev_eoc |=> s_reg.dready && s_reg.result == $past(conv_word)
            && (HIRES || s_reg.result[AISC_HR_BITS-1:AISC_STD_BITS] == '0);
    endproperty
    a_result: assert property (p_result) else $error("result not captured");

    property p_overrun;
        @(posedge clk_i) disable iff (rst_i)
        fifo_full_i |=> s_reg.irq_stat[AISC_EV_OVR]
            ##1 (s_reg.irq_stat[AISC_EV_OVR] || $past(wr_irq_clr));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule : aisc_top

// ### verification/aisc_adc_model.sv
// Converter stand-in that answers start pulses
module aisc_adc_model (
    // Clock, reset and start
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [3:0] ch_i,
    // Result and done
    output logic done_o,
    output logic [15:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    // Data settles before done rises; inverted later so stale reads show
    always @(posedge clk_i) begin
        if (rst_i) begin
            n <= 0;
            done_o <= 1'b0;
            dat_o <= 16'h0000;
        end else if (go_i) begin
            n <= 1;
            dat_o <= {4'ha, ch_i, 8'h5c};
        end else if (n > 0) begin
            n <= (n == 8) ? 0 : n + 1;
            done_o <= n >= 4 && n < 7;
            if (n == 8) dat_o <= ~dat_o;
        end
    end
endmodule : aisc_adc_model

// ### verification/acq_interrupt_and_scan_ctrl_tb.sv
// Self-checking bench for the interrupt and scan block
module acq_interrupt_and_scan_ctrl_tb
    import aisc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d;} aisc_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic half = 1'b0, full = 1'b0, ext = 1'b0;
    logic ack, irq, l1, l2, cs, done, pto;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q, rdat_hr, q_hr;
    logic [3:0] ch;
    logic [15:0] ad;
    int mismatches = 0, num_checks = 0, cycles = 0, nrd = 0;
    // Register accesses: write rows, or read rows with expected value
    aisc_row_t rows [10] = '{'{1'b0, 8'h00, 32'h0}, '{1'b1, 8'h00, 32'hffffffff},
        '{1'b0, 8'h00, 32'h0f3f}, '{1'b1, 8'h00, 32'h0}, '{1'b1, 8'h14, 32'h1234},
        '{1'b0, 8'h14, 32'h1234}, '{1'b1, 8'h20, 32'h1f}, '{1'b0, 8'h20, 32'h1f},
        '{1'b0, 8'h3c, 32'h0}, '{1'b0, 8'h10, 32'h0}};
    aisc_top aisc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .first_irq_line_o(l1), .second_irq_line_o(l2),
        .conv_start_o(cs), .adc_channel_o(ch), .adc_done_i(done), .adc_data_i(ad),
        .fifo_half_i(half), .fifo_full_i(full), .ext_irq_i(ext), .pretrig_out_o(pto));
    aisc_adc_model aisc_adc_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(cs),
        .ch_i(ch), .done_o(done), .dat_o(ad));
    // High-resolution twin shares the bus and the converter
    aisc_top #(.HIRES(1'b1)) aisc_top_hr_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
        .wb_dat_o(rdat_hr), .wb_ack_o(), .irq_o(), .first_irq_line_o(), .second_irq_line_o(),
        .conv_start_o(), .adc_channel_o(), .adc_done_i(done), .adc_data_i(ad),
        .fifo_half_i(half), .fifo_full_i(full), .ext_irq_i(ext), .pretrig_out_o());
    // Clock and hang guard
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One classic cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        q_hr = rdat_hr;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        chk("ack", {31'h0, ack}, 32'h0);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rd
    // Software trigger, poll data ready, check channel and masked result
    task automatic conv(input logic [3:0] ec);
        int n = 0;
        wb(1'b1, AISC_OFF_SWTRIG, 32'h1);
        do begin
            wb(1'b0, AISC_OFF_STAT, 32'h0);
            n++;
        end while (q[AISC_ST_DREADY] !== 1'b1 && n < 20);
        chk("dready", {31'h0, q[AISC_ST_DREADY]}, 32'h1);
        chk("channel", {28'h0, ch}, {28'h0, ec});
        rd(AISC_OFF_DATA, {20'h0, ec, 8'h5c}, "data");
        chk("data16", q_hr, {16'h0, 4'ha, ec, 8'h5c});
    endtask : conv
    // Half-full poll: skip while inactive or full, else drain one block
    task automatic poll;
        nrd = 0;
        wb(1'b0, AISC_OFF_STAT, 32'h0);
        if (q[AISC_ST_HALF] && !q[AISC_ST_FULL]) begin
            repeat (512) begin
                wb(1'b0, AISC_OFF_DATA, 32'h0);
                nrd++;
            end
        end
    endtask : poll
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
            else rd(rows[i].a, rows[i].d, "reg");
        end
        // Both lines pending, held, then dropped by one clear
        wb(1'b1, AISC_OFF_CTRL, 32'h0309);
        ext <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext <= 1'b0;
        conv(4'h3);
        chk("lines", {30'h0, l1, l2}, 32'h3);
        wb(1'b1, AISC_OFF_PEND_CLR, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("lines", {30'h0, l1, l2}, 32'h0);
        // Autoscan wraps after the last channel
        wb(1'b1, AISC_OFF_CTRL, 32'h0210);
        for (int i = 0; i < 4; i++) conv(4'(i % 3));
        // Zero divider stops pacing; nonzero pair paces
        wb(1'b1, AISC_OFF_CTRL, 32'h0024);
        repeat (40) @(posedge clk_i);
        chk("pacer", {31'h0, l2}, 32'h0);
        wb(1'b1, AISC_OFF_PACER_A, 32'h3);
        wb(1'b1, AISC_OFF_PACER_B, 32'h2);
        repeat (40) @(posedge clk_i);
        chk("pacer", {31'h0, l2}, 32'h1);
        wb(1'b1, AISC_OFF_CTRL, 32'h0);
        // Full FIFO raises overrun interrupt; half-full visible
        wb(1'b1, AISC_OFF_IRQ_EN, 32'h10);
        poll();
        chk("poll", nrd, 32'h0);
        half <= 1'b1;
        full <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("irq", {31'h0, irq}, 32'h1);
        full <= 1'b0;
        wb(1'b0, AISC_OFF_STAT, 32'h0);
        chk("half", {31'h0, q[AISC_ST_HALF]}, 32'h1);
        poll();
        chk("poll", nrd, 32'h200);
        wb(1'b1, AISC_OFF_IRQ_CLR, 32'h1f);
        repeat (2) @(posedge clk_i);
        chk("irq", {31'h0, irq}, 32'h0);
        // Counter read twice is undisturbed; zero one-shot halts high
        wb(1'b1, AISC_OFF_PRETRIG, 32'h5);
        rd(AISC_OFF_PRETRIG, 32'h5, "count");
        rd(AISC_OFF_PRETRIG, 32'h5, "count");
        wb(1'b1, AISC_OFF_PRETRIG, 32'h0001_0000);
        repeat (2) @(posedge clk_i);
        chk("pretrig", {31'h0, pto}, 32'h1);
        rd(AISC_OFF_PRETRIG, 32'h0, "count");
        // Mid-run reset clears lines, counter output and pacer divider A
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset", {28'h0, irq, l1, l2, pto}, 32'h0);
        rd(AISC_OFF_PACER_A, 32'h0, "divider");
        complete_run();
    end
endmodule : acq_interrupt_and_scan_ctrl_tb
